//--- core/sbc_bridge.sv
// stepper bridge control: decode, protection latches, chopper clock, apb registers
`timescale 1ns/1ns
`default_nettype none
module sbc_bridge (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               dir_first,
  input  wire logic               level_sel0_first,
  input  wire logic               level_sel1_first,
  input  wire logic               dir_second,
  input  wire logic               level_sel0_second,
  input  wire logic               level_sel1_second,
  input  wire logic               standby_n,
  input  wire logic               thermal_trip,
  input  wire logic [1:0]         overcurrent_trip,
  input  wire logic               motor_supply_good,
  input  wire logic               logic_supply_good,
  output var  sbc_pkg::sbc_drive_s drive_first,
  output var  sbc_pkg::sbc_drive_s drive_second,
  output var  logic               chop_osc,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  output var  logic               irq
);
  // input synchroniser
  logic [sbc_pkg::SY_W-1:0] sync1_q;
  logic [sbc_pkg::SY_W-1:0] sync2_q;
  logic                     stby_prev_q;
  logic                     por_prev_q;
  logic [sbc_pkg::SY_W-1:0] sync_in;
  always_comb begin
    sync_in                         = '0;
    sync_in[sbc_pkg::SY_STBY]       = standby_n;
    sync_in[sbc_pkg::SY_TSD]        = thermal_trip;
    sync_in[sbc_pkg::SY_OC_FIRST]   = overcurrent_trip[0];
    sync_in[sbc_pkg::SY_OC_SECOND]  = overcurrent_trip[1];
    sync_in[sbc_pkg::SY_VM]         = motor_supply_good;
    sync_in[sbc_pkg::SY_VCC]        = logic_supply_good;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      stby_prev_q <= 1'b0;
      por_prev_q  <= 1'b0;
    end else begin
      sync1_q     <= sync_in;
      sync2_q     <= sync1_q;
      stby_prev_q <= sync2_q[sbc_pkg::SY_STBY];
      por_prev_q  <= sync2_q[sbc_pkg::SY_VM] & sync2_q[sbc_pkg::SY_VCC];
    end
  end
  logic       stby_s;
  logic       tsd_s;
  logic [1:0] oc_s;
  logic       por_ok;
  logic       stby_rise;
  assign stby_s    = sync2_q[sbc_pkg::SY_STBY];
  assign tsd_s     = sync2_q[sbc_pkg::SY_TSD];
  assign oc_s      = {sync2_q[sbc_pkg::SY_OC_SECOND], sync2_q[sbc_pkg::SY_OC_FIRST]};
  assign por_ok    = sync2_q[sbc_pkg::SY_VM] & sync2_q[sbc_pkg::SY_VCC];
  assign stby_rise = stby_s & ~stby_prev_q;
  // chopper oscillator and protection latches
  logic [15:0] chop_div_q;
  logic [15:0] chop_cnt_q;
  logic [15:0] chop_cnt_d;
  logic        chop_osc_q;
  logic        chop_osc_d;
  logic        tsd_q;
  logic        tsd_d;
  logic [1:0]  oc_q;
  logic [1:0]  oc_d;
  logic [2:0]  oc_cnt_q [2];
  logic [2:0]  oc_cnt_d [2];
  logic        chop_run;
  logic        osc_cycle;
  logic [1:0]  oc_set;
  logic        tsd_set;
  always_comb begin
    chop_run   = stby_s & por_ok & ~tsd_q & ~(|oc_q);
    chop_cnt_d = chop_cnt_q;
    chop_osc_d = chop_osc_q;
    osc_cycle  = 1'b0;
    if (!chop_run) begin
      chop_cnt_d = '0;
      chop_osc_d = 1'b0;
    end else if (chop_cnt_q >= chop_div_q) begin
      chop_cnt_d = '0;
      chop_osc_d = ~chop_osc_q;
      osc_cycle  = chop_osc_q;
    end else begin
      chop_cnt_d = chop_cnt_q + 16'h0001;
    end
    tsd_set = tsd_s & ~tsd_q;
    tsd_d   = tsd_q;
    if (stby_rise) begin
      tsd_d = 1'b0;
    end
    if (tsd_s) begin
      tsd_d = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      oc_cnt_d[i] = oc_cnt_q[i];
      oc_set[i]   = 1'b0;
      oc_d[i]     = oc_q[i];
      if (!oc_s[i] || oc_q[i]) begin
        oc_cnt_d[i] = '0;
      end else if (oc_cnt_q[i] == sbc_pkg::OC_MASK_CYC) begin
        oc_set[i]   = 1'b1;
        oc_cnt_d[i] = '0;
      end else if (osc_cycle) begin
        oc_cnt_d[i] = oc_cnt_q[i] + 3'h1;
      end
      if (stby_rise) begin
        oc_d[i] = 1'b0;
      end
      if (oc_set[i]) begin
        oc_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chop_cnt_q  <= '0;
      chop_osc_q  <= 1'b0;
      tsd_q       <= 1'b0;
      oc_q        <= '0;
      oc_cnt_q[0] <= '0;
      oc_cnt_q[1] <= '0;
    end else begin
      chop_cnt_q  <= chop_cnt_d;
      chop_osc_q  <= chop_osc_d;
      tsd_q       <= tsd_d;
      oc_q        <= oc_d;
      oc_cnt_q[0] <= oc_cnt_d[0];
      oc_cnt_q[1] <= oc_cnt_d[1];
    end
  end
  // phase decode
  function automatic sbc_pkg::sbc_drive_s decode(input sbc_pkg::sbc_cmd_s c,
                                                  input logic ok);
    sbc_pkg::sbc_drive_s d;
    d = '0;
    if (ok && (c.sel0 || c.sel1)) begin
      d.en  = 1'b1;
      d.pos = c.dir;
      d.neg = ~c.dir;
      if (c.sel0 && c.sel1) begin
        d.level = sbc_pkg::LVL_100;
      end else if (c.sel0) begin
        d.level = sbc_pkg::LVL_71;
      end else begin
        d.level = sbc_pkg::LVL_38;
      end
    end
    return d;
  endfunction
  sbc_pkg::sbc_drive_s drv_q [2];
  sbc_pkg::sbc_drive_s drv_d [2];
  sbc_pkg::sbc_cmd_s   cmd   [2];
  logic [1:0]          ph_ok;
  sbc_pkg::sbc_mode_e  mode_q;
  sbc_pkg::sbc_mode_e  mode_d;
  always_comb begin
    cmd[0] = '{dir: dir_first, sel0: level_sel0_first, sel1: level_sel1_first};
    cmd[1] = '{dir: dir_second, sel0: level_sel0_second, sel1: level_sel1_second};
    for (int i = 0; i < 2; i++) begin
      ph_ok[i] = stby_s & por_ok & ~tsd_q & ~oc_q[i];
      drv_d[i] = decode(cmd[i], ph_ok[i]);
    end
    if (!por_ok) begin
      mode_d = sbc_pkg::SBC_POR;
    end else if (tsd_q) begin
      mode_d = sbc_pkg::SBC_TSD;
    end else if (|oc_q) begin
      mode_d = sbc_pkg::SBC_ISD;
    end else if (!stby_s) begin
      mode_d = sbc_pkg::SBC_STBY;
    end else begin
      mode_d = sbc_pkg::SBC_RUN;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drv_q[0] <= '0;
      drv_q[1] <= '0;
      mode_q   <= sbc_pkg::SBC_POR;
    end else begin
      drv_q[0] <= drv_d[0];
      drv_q[1] <= drv_d[1];
      mode_q   <= mode_d;
    end
  end
  assign drive_first  = drv_q[0];
  assign drive_second = drv_q[1];
  assign chop_osc     = chop_osc_q;
  // apb slave, status, mask, interrupt
  logic [31:0]              prdata_q;
  logic [31:0]              prdata_d;
  logic                     pready_q;
  logic                     pready_d;
  logic                     pslverr_q;
  logic                     pslverr_d;
  logic                     irq_q;
  logic                     irq_d;
  logic [sbc_pkg::ST_W-1:0] status_q;
  logic [sbc_pkg::ST_W-1:0] status_d;
  logic [sbc_pkg::ST_W-1:0] mask_q;
  logic [sbc_pkg::ST_W-1:0] mask_d;
  logic [15:0]              chop_div_d;
  logic [sbc_pkg::ST_W-1:0] events;
  logic                     done;
  always_comb begin
    events                        = '0;
    events[sbc_pkg::ST_TSD]       = tsd_set;
    events[sbc_pkg::ST_OC_FIRST]  = oc_set[0];
    events[sbc_pkg::ST_OC_SECOND] = oc_set[1];
    events[sbc_pkg::ST_SUPPLY]    = por_prev_q & ~por_ok;
    done       = psel & penable & pready_q;
    prdata_d   = '0;
    pready_d   = 1'b0;
    pslverr_d  = 1'b0;
    mask_d     = mask_q;
    chop_div_d = chop_div_q;
    status_d   = status_q | events;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      case (paddr)
        sbc_pkg::OFS_STATUS:   prdata_d = {28'h000_0000, status_q};
        sbc_pkg::OFS_MASK:     prdata_d = {28'h000_0000, mask_q};
        sbc_pkg::OFS_STATE:    prdata_d = {24'h00_0000, mode_q, stby_s, por_ok, oc_q, tsd_q};
        sbc_pkg::OFS_CHOP_DIV: prdata_d = {16'h0000, chop_div_q};
        default:               pslverr_d = 1'b1;
      endcase
    end
    if (done && pwrite) begin
      if (paddr == sbc_pkg::OFS_MASK) begin
        mask_d = pwdata[sbc_pkg::ST_W-1:0];
      end
      if (paddr == sbc_pkg::OFS_CHOP_DIV) begin
        chop_div_d = pwdata[15:0];
      end
    end
    if (done && !pwrite && paddr == sbc_pkg::OFS_STATUS) begin
      status_d = (status_q & ~prdata_q[sbc_pkg::ST_W-1:0]) | events;
    end
    irq_d = |(status_d & mask_d);
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q   <= '0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      irq_q      <= 1'b0;
      status_q   <= '0;
      mask_q     <= sbc_pkg::MASK_RST;
      chop_div_q <= sbc_pkg::CHOP_DIV_RST;
    end else begin
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      irq_q      <= irq_d;
      status_q   <= status_d;
      mask_q     <= mask_d;
      chop_div_q <= chop_div_d;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  fwd_full_level_a: assert property (
    ph_ok[0] && dir_first && level_sel0_first && level_sel1_first |=>
      drive_first.pos && !drive_first.neg && drive_first.level == sbc_pkg::LVL_100)
    else $error("forward full level not driven");
  rev_low_level_a: assert property (
    ph_ok[1] && !dir_second && !level_sel0_second && level_sel1_second |=>
      !drive_second.pos && drive_second.neg && drive_second.level == sbc_pkg::LVL_38)
    else $error("reverse low level not driven");
  zero_disable_a: assert property (
    !level_sel0_first && !level_sel1_first |=>
      !drive_first.en && drive_first.level == sbc_pkg::LVL_0)
    else $error("zero level phase still enabled");
  standby_off_a: assert property (
    !stby_s |=> !drive_first.en && !drive_second.en && !chop_osc)
    else $error("drive active in standby");
  thermal_off_a: assert property (
    tsd_s && !tsd_q |=> tsd_q ##1 (!drive_first.en && !drive_second.en))
    else $error("thermal trip did not switch off outputs");
  thermal_hold_a: assert property (
    tsd_q && !stby_rise |=> tsd_q)
    else $error("thermal shutdown left without standby cycle");
  supply_off_a: assert property (
    !por_ok |=> !drive_first.en && !drive_second.en)
    else $error("outputs on with supply not good");
  oc_phase_off_a: assert property (
    $rose(oc_q[0]) |=> !drive_first.en && oc_q[0])
    else $error("overcurrent phase not switched off");
  oc_hold_a: assert property (
    oc_q[1] && !stby_rise |=> oc_q[1])
    else $error("overcurrent shutdown left without standby cycle");
  oc_filter_a: assert property (
    $rose(oc_q[0]) |-> $past(oc_cnt_q[0]) == sbc_pkg::OC_MASK_CYC && $past(oc_s[0]))
    else $error("overcurrent latched before filter time");
  oc_osc_stop_a: assert property (
    (|oc_q) ##1 (|oc_q) |-> !chop_osc)
    else $error("oscillator runs in overcurrent shutdown");
  sync_clear_a: assert property (
    $fell(tsd_q) |-> $past(stby_rise) && !$past(tsd_s))
    else $error("thermal latch cleared without synced standby rise");
endmodule // sbc_bridge
`default_nettype wire

//--- core/sbc_pkg.sv
// shared constants and types of the stepper bridge control block
package sbc_pkg;
  // apb register map, byte addresses
  localparam int             ADDR_W       = 8;
  localparam logic [7:0]     OFS_STATUS   = 8'h00;
  localparam logic [7:0]     OFS_MASK     = 8'h04;
  localparam logic [7:0]     OFS_STATE    = 8'h08;
  localparam logic [7:0]     OFS_CHOP_DIV = 8'h0c;
  // status and mask bit positions
  localparam int             ST_TSD       = 0;
  localparam int             ST_OC_FIRST  = 1;
  localparam int             ST_OC_SECOND = 2;
  localparam int             ST_SUPPLY    = 3;
  localparam int             ST_W         = 4;
  // reset values
  localparam logic [3:0]     MASK_RST     = 4'h0;
  localparam logic [15:0]    CHOP_DIV_RST = 16'h0032;
  // overcurrent filter length in oscillator cycles
  localparam logic [2:0]     OC_MASK_CYC  = 3'h4;
  // current level codes
  localparam logic [1:0]     LVL_0        = 2'h0;
  localparam logic [1:0]     LVL_38       = 2'h1;
  localparam logic [1:0]     LVL_71       = 2'h2;
  localparam logic [1:0]     LVL_100      = 2'h3;
  // synchroniser bit positions
  localparam int             SY_STBY      = 0;
  localparam int             SY_TSD       = 1;
  localparam int             SY_OC_FIRST  = 2;
  localparam int             SY_OC_SECOND = 3;
  localparam int             SY_VM        = 4;
  localparam int             SY_VCC       = 5;
  localparam int             SY_W         = 6;

  typedef enum logic [2:0] {
    SBC_POR,
    SBC_STBY,
    SBC_RUN,
    SBC_TSD,
    SBC_ISD
  } sbc_mode_e;

  typedef struct packed {
    logic       dir;
    logic       sel0;
    logic       sel1;
  } sbc_cmd_s;

  typedef struct packed {
    logic       en;
    logic       pos;
    logic       neg;
    logic [1:0] level;
  } sbc_drive_s;
endpackage

//--- sim/sbc_motion_model.sv
// motion controller model driving direction and level pins
`timescale 1ns/1ns
`default_nettype none
module sbc_motion_model (
  input  wire logic              core_clk,
  input  wire logic              supply_up,
  input  wire sbc_pkg::sbc_cmd_s cmd_first,
  input  wire sbc_pkg::sbc_cmd_s cmd_second,
  output var  logic              dir_first,
  output var  logic              level_sel0_first,
  output var  logic              level_sel1_first,
  output var  logic              dir_second,
  output var  logic              level_sel0_second,
  output var  logic              level_sel1_second
);
  // static levels, held low until the motor supply is up
  always_ff @(posedge core_clk) begin
    if (supply_up) begin
      {dir_first, level_sel0_first, level_sel1_first}    <= cmd_first;
      {dir_second, level_sel0_second, level_sel1_second} <= cmd_second;
    end else begin
      {dir_first, level_sel0_first, level_sel1_first}    <= 3'h0;
      {dir_second, level_sel0_second, level_sel1_second} <= 3'h0;
    end
  end
endmodule // sbc_motion_model
`default_nettype wire

//--- sim/tb_stepper_bridge_control.sv
// self-checking bench of the stepper bridge control block
`timescale 1ns/1ns
`default_nettype none
module tb_stepper_bridge_control;
  logic core_clk = 1'b0, sys_rst = 1'b1, standby_n = 1'b1, thermal_trip = 1'b0;
  logic [1:0] overcurrent_trip = 2'h0;
  logic motor_supply_good = 1'b0, logic_supply_good = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, irq, chop_osc, err;
  logic dir_first, level_sel0_first, level_sel1_first;
  logic dir_second, level_sel0_second, level_sel1_second;
  sbc_pkg::sbc_cmd_s   cmd_first = 3'h0, cmd_second = 3'h0;
  sbc_pkg::sbc_drive_s drive_first, drive_second;
  int n_fail = 0, n_tests = 0, t;

  always #50 core_clk = ~core_clk;

  sbc_motion_model sbc_motion_model_inst (.core_clk(core_clk), .supply_up(motor_supply_good),
    .cmd_first(cmd_first), .cmd_second(cmd_second), .dir_first(dir_first),
    .level_sel0_first(level_sel0_first), .level_sel1_first(level_sel1_first),
    .dir_second(dir_second), .level_sel0_second(level_sel0_second),
    .level_sel1_second(level_sel1_second));

  sbc_bridge sbc_bridge_inst (.core_clk(core_clk), .sys_rst(sys_rst), .dir_first(dir_first),
    .level_sel0_first(level_sel0_first), .level_sel1_first(level_sel1_first),
    .dir_second(dir_second), .level_sel0_second(level_sel0_second),
    .level_sel1_second(level_sel1_second), .standby_n(standby_n), .thermal_trip(thermal_trip),
    .overcurrent_trip(overcurrent_trip), .motor_supply_good(motor_supply_good),
    .logic_supply_good(logic_supply_good), .drive_first(drive_first),
    .drive_second(drive_second), .chop_osc(chop_osc), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // wait for pready; only the watchdog ends a hung transfer
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic [4:0] exp_drv(sbc_pkg::sbc_cmd_s c);
    logic en;
    en = c.sel0 | c.sel1;
    exp_drv = {en, en & c.dir, en & ~c.dir, (c.sel0 & c.sel1) ? sbc_pkg::LVL_100 :
      c.sel0 ? sbc_pkg::LVL_71 : c.sel1 ? sbc_pkg::LVL_38 : sbc_pkg::LVL_0};
  endfunction

  task automatic chk_drv(logic on1, logic on2);
    check("drive_first", 32'(drive_first), on1 ? 32'(exp_drv(cmd_first)) : 32'h0);
    check("drive_second", 32'(drive_second), on2 ? 32'(exp_drv(cmd_second)) : 32'h0);
  endtask

  task automatic osc_edges(int n);
    logic p;
    p = chop_osc;
    t = 0;
    repeat (n) begin
      @(posedge core_clk);
      if (chop_osc !== p) t++;
      p = chop_osc;
    end
  endtask

  task automatic stby_cycle();
    standby_n <= 1'b0;
    tick(6);
    standby_n <= 1'b1;
    tick(6);
  endtask

  task automatic test_regs();
    apb(1'b0, sbc_pkg::OFS_CHOP_DIV, 32'h0);
    check("chop_div_rst", rd, 32'h0000_0032);
    apb(1'b0, sbc_pkg::OFS_MASK, 32'h0);
    check("mask_rst", rd, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h0000_0001);
    apb(1'b1, sbc_pkg::OFS_CHOP_DIV, 32'h0000_0002);
    apb(1'b1, sbc_pkg::OFS_MASK, 32'h0000_0001);
    apb(1'b0, sbc_pkg::OFS_MASK, 32'h0);
    check("mask_rw", rd, 32'h0000_0001);
    $display("test regs done");
  endtask

  task automatic test_decode();
    for (int i = 0; i < 8; i++) begin
      cmd_first <= 3'(i);
      cmd_second <= ~3'(i);
      tick(4);
      chk_drv(1'b1, 1'b1);
    end
    cmd_first <= 3'h7;
    cmd_second <= 3'h2;
    tick(4);
    $display("test decode done");
  endtask

  task automatic test_standby();
    standby_n <= 1'b0;
    tick(6);
    chk_drv(1'b0, 1'b0);
    osc_edges(20);
    check("osc_stby", 32'(t), 32'h0);
    standby_n <= 1'b1;
    tick(6);
    chk_drv(1'b1, 1'b1);
    osc_edges(20);
    check("osc_run", {31'h0, t >= 6}, 32'h0000_0001);
    $display("test standby done");
  endtask

  task automatic test_thermal();
    thermal_trip <= 1'b1;
    tick(6);
    chk_drv(1'b0, 1'b0);
    check("irq_set", {31'h0, irq}, 32'h0000_0001);
    thermal_trip <= 1'b0;
    tick(6);
    chk_drv(1'b0, 1'b0);
    apb(1'b0, sbc_pkg::OFS_STATUS, 32'h0);
    check("status_tsd", rd, 32'h0000_0001);
    apb(1'b0, sbc_pkg::OFS_STATUS, 32'h0);
    check("status_clr", rd, 32'h0000_0000);
    check("irq_clr", {31'h0, irq}, 32'h0000_0000);
    stby_cycle();
    chk_drv(1'b1, 1'b1);
    $display("test thermal done");
  endtask

  task automatic test_supply();
    motor_supply_good <= 1'b0;
    tick(6);
    chk_drv(1'b0, 1'b0);
    motor_supply_good <= 1'b1;
    logic_supply_good <= 1'b0;
    tick(6);
    chk_drv(1'b0, 1'b0);
    logic_supply_good <= 1'b1;
    tick(6);
    chk_drv(1'b1, 1'b1);
    apb(1'b0, sbc_pkg::OFS_STATUS, 32'h0);
    check("status_supply", rd, 32'h0000_0008);
    $display("test supply done");
  endtask

  task automatic test_overcurrent();
    overcurrent_trip <= 2'h1;
    tick(10);
    overcurrent_trip <= 2'h0;
    tick(40);
    chk_drv(1'b1, 1'b1);
    overcurrent_trip <= 2'h1;
    tick(60);
    overcurrent_trip <= 2'h0;
    tick(6);
    chk_drv(1'b0, 1'b1);
    osc_edges(20);
    check("osc_isd", 32'(t), 32'h0);
    apb(1'b0, sbc_pkg::OFS_STATUS, 32'h0);
    check("status_oc_first", rd, 32'h0000_0002);
    apb(1'b0, sbc_pkg::OFS_STATE, 32'h0);
    check("state_isd", rd, 32'h0000_009a);
    stby_cycle();
    chk_drv(1'b1, 1'b1);
    overcurrent_trip <= 2'h2;
    tick(60);
    overcurrent_trip <= 2'h0;
    tick(6);
    chk_drv(1'b1, 1'b0);
    apb(1'b0, sbc_pkg::OFS_STATUS, 32'h0);
    check("status_oc_second", rd, 32'h0000_0004);
    stby_cycle();
    chk_drv(1'b1, 1'b1);
    $display("test overcurrent done");
  endtask

  initial begin
    #2_000_000;
    n_fail++;
    print_verdict();
  end

  initial begin
    tick(12);
    sys_rst <= 1'b0;
    motor_supply_good <= 1'b1;
    tick(6);
    test_regs();
    test_decode();
    test_standby();
    test_thermal();
    test_supply();
    test_overcurrent();
    print_verdict();
  end
endmodule // tb_stepper_bridge_control
`default_nettype wire
